// ==== dv/fet_bridge_model.sv ====
// Bridge-side model: measures the PWM period seen at the gate driver
`timescale 1ns/1ns
`default_nettype none
module fet_bridge_model (
  input  wire logic       clk_i,       // Bench clock
  input  wire logic       rst_i,       // Sync reset, active high
  input  wire logic       pwm_cycle_i, // End of PWM period pulse
  output logic      [9:0] period_o     // Last full period, in cycles
);
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [9:0] per_d;
  always_comb begin
    cnt_d = pwm_cycle_i ? 10'h001 : cnt_q + 10'h001;
    per_d = pwm_cycle_i ? cnt_q : period_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q    <= 10'h001;
      period_o <= 10'h000;
    end else begin
      cnt_q    <= cnt_d;
      period_o <= per_d;
    end
  end
endmodule // fet_bridge_model
`default_nettype wire

// ==== dv/motor_drive_setting_select_bench.sv ====
// Self-checking bench for the drive setting selector
`timescale 1ns/1ns
`default_nettype none
module motor_drive_setting_select_bench;
  import motor_set_pkg::*;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err, dir_ccw, brake, pcyc;
  logic        dir_pin = 1'b0;
  logic        brk_pin = 1'b0;
  logic [15:0] speed = 16'h0;
  logic [3:0]  lead;
  logic [1:0]  div;
  logic [9:0]  period;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Speeds rise, fall, then rise again so the rows walk both band edges
  localparam logic [15:0] R_CTRL [11] = '{16'h0008, 16'h1306, 16'h2108, 16'h4208, 16'h8008,
    16'h241F, 16'h041B, 16'h041B, 16'h070C, 16'hC50E, 16'h1620};
  localparam logic [15:0] R_SPD [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h03E9, 16'h03B6, 16'h0384, 16'h0096, 16'h0258, 16'h0258};
  localparam logic [1:0] R_PIN [11] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h2};
  localparam logic [7:0] R_EXP [11] = '{8'h08, 8'hF6, 8'hD8, 8'hE6, 8'h04, 8'h38, 8'h35,
    8'h24, 8'h12, 8'h24, 8'h10};
  motor_drive_setting_select i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rotation_dir_pin_i(dir_pin),
    .brake_pin_i(brk_pin), .elec_speed_hz_i(speed), .dir_ccw_o(dir_ccw),
    .short_brake_o(brake), .lead_angle_o(lead), .pwm_div_o(div), .pwm_cycle_o(pcyc));
  fet_bridge_model i_bridge (.clk_i(mclk_i), .rst_i(sys_rst_i), .pwm_cycle_i(pcyc),
    .period_o(period));
  always #20 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 20) mismatches++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, {16'h0, CTRL_RESET});
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, CTRL_OFS, {16'h0, R_CTRL[i]});
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, {16'h0, R_CTRL[i]});
      @(posedge mclk_i);
      {dir_pin, brk_pin} <= R_PIN[i];
      speed <= R_SPD[i];
      repeat (1200) @(posedge mclk_i);
      chk({24'h0, brake, dir_ccw, div, lead}, {24'h0, R_EXP[i]});
      apb(1'b0, STATUS_OFS, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, R_EXP[i]});
      chk({22'h0, period}, 32'h200 >> R_EXP[i][5:4]);
      $display("row %0d done", i);
    end
    // Unmapped and read-only places must leave the control word alone
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'hFFFFFFFF);
    apb(1'b1, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, STATUS_OFS, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, {16'h0, CTRL_MASK});
    $display("register access test done");
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk({21'h0, pready, pslverr, pcyc, brake, dir_ccw, div, lead}, 32'h0);
    chk(prdata, 32'h0);
    sys_rst_i <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, {16'h0, CTRL_RESET});
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule // motor_drive_setting_select_bench
`default_nettype wire

// ==== rtl/motor_drive_setting_select.sv ====
// Drive setting selector: direction, brake, lead angle and PWM divider
//
// Overview of operation
// - Direction is the pin XOR the invert bit; low with bit 0 means CW.
// - Short brake when brake pin matches active level; polarity bit 1 means low active.
// - PWM period is the internal clock divided by 512, 256, 128 or 64.
// - Frequency codes 0 to 3 pick a fixed divider regardless of speed.
// - Codes 4 to 7 pick divider per speed band, 200 Hz edges, 100 Hz hysteresis.
// - Lead codes 0 to 8 fixed 3.75 degree steps; 9 to 15 banded lookup.
// - Applied lead is clamped by commutation angle: 30, 22.5 or 15 degrees.
`timescale 1ns/1ns
`default_nettype none
module motor_drive_setting_select (
  input  wire logic        mclk_i,           // 25 MHz clock
  input  wire logic        sys_rst_i,        // Sync reset, active high
  input  wire logic        psel_i,           // APB select
  input  wire logic        penable_i,        // APB enable
  input  wire logic        pwrite_i,         // APB write
  input  wire logic [7:0]  paddr_i,          // APB byte address
  input  wire logic [31:0] pwdata_i,         // APB write data
  output logic      [31:0] prdata_o,         // APB read data
  output logic             pready_o,         // APB ready
  output logic             pslverr_o,        // APB error, unmapped
  input  wire logic        rotation_dir_pin_i, // Direction pin level
  input  wire logic        brake_pin_i,      // Brake pin level
  input  wire logic [15:0] elec_speed_hz_i,  // Electrical speed, Hz
  output logic             dir_ccw_o,        // 1 = CCW, 0 = CW
  output logic             short_brake_o,    // Short brake request
  output logic      [3:0]  lead_angle_o,     // Applied lead, 3.75 deg units
  output logic      [1:0]  pwm_div_o,        // 0..3 = /512 /256 /128 /64
  output logic             pwm_cycle_o       // One pulse per PWM period
);
  import motor_set_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        access, hit_ctrl, hit_stat;
  logic [2:0]  band_lead_q, band_lead_d, band_pwm_q, band_pwm_d;
  logic        dir_q, dir_d, brk_q, brk_d;
  logic [3:0]  lead_q, lead_d;
  logic [1:0]  div_q, div_d;
  logic [8:0]  cnt_q, cnt_d;
  logic        cyc_q, cyc_d;

  always_comb begin
    access    = psel_i && penable_i && !pready_q;
    hit_ctrl  = paddr_i == CTRL_OFS;
    hit_stat  = paddr_i == STATUS_OFS;
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pready_d  = access;
    pslverr_d = access && !hit_ctrl && !hit_stat;
    // Write lands only at the edge where the master sees pready high
    if (psel_i && penable_i && pready_q && pwrite_i && hit_ctrl) begin
      ctrl_d = pwdata_i[15:0] & CTRL_MASK;
    end
    if (access) begin
      if (!pwrite_i && hit_ctrl) begin
        prdata_d = {16'h0000, ctrl_q};
      end else if (!pwrite_i && hit_stat) begin
        prdata_d = {16'h0000, band_pwm_q, 1'b0, band_lead_q, cyc_q,
                    brk_q, dir_q, div_q, lead_q};
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q    <= CTRL_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed bands with hysteresis; one step per clock is ample for a speed input
  function automatic logic [2:0] next_band(input logic [2:0] b, input logic [15:0] f,
                                           input logic [15:0] step, input logic [15:0] ofs);
    logic [18:0] up_thr;
    logic [18:0] dn_thr;
    up_thr = 19'({16'h0000, b} + 19'h1) * 19'(step);
    dn_thr = 19'(b) * 19'(step) - 19'(ofs);
    next_band = b;
    if (b != BAND_TOP && 19'(f) > up_thr) begin
      next_band = 3'(b + 3'h1);
    end else if (b != 3'h0 && 19'(f) <= dn_thr) begin
      next_band = 3'(b - 3'h1);
    end
  endfunction

  logic [1:0] scale, comm;
  logic [3:0] lsel, lraw, llim;
  logic [2:0] fsel;
  always_comb begin
    scale = ctrl_q[SCALE_LSB +: 2];
    comm  = ctrl_q[COMM_LSB +: 2];
    lsel  = ctrl_q[LEAD_LSB +: 4];
    fsel  = ctrl_q[PWMF_LSB +: 3];
    if (scale == 2'h0) begin
      band_lead_d = next_band(band_lead_q, elec_speed_hz_i, STEP_FINE, OFS_FINE);
    end else begin
      band_lead_d = next_band(band_lead_q, elec_speed_hz_i, STEP_COARSE, OFS_COARSE);
    end
    band_pwm_d = next_band(band_pwm_q, elec_speed_hz_i, STEP_COARSE, OFS_COARSE);
    dir_d = rotation_dir_pin_i ^ ctrl_q[DIRINV];
    brk_d = brake_pin_i ^ ctrl_q[BRKINV];
    if (lsel <= LEAD_FIXED_MAX) begin
      lraw = lsel;
    end else begin
      lraw = LEAD_TBL[3'(lsel - 4'h9)][band_lead_q];
    end
    case (comm)
      COMM_120: llim = LEAD_LIM_120;
      COMM_135: llim = LEAD_LIM_135;
      default:  llim = LEAD_LIM_150;
    endcase
    lead_d = (lraw > llim) ? llim : lraw;
    if (fsel < PWMF_BANDED) begin
      div_d = fsel[1:0];
    end else begin
      div_d = PWM_TBL[fsel[1:0]][band_pwm_q];
    end
    // New divider takes effect at the next period boundary, avoiding runt periods
    // 512 wraps to zero in nine bits, so the terminal count still comes out at 511
    if (cnt_q == 9'(PWM_DIV_MAX >> div_q) - 9'h1) begin
      cnt_d = 9'h000;
      cyc_d = 1'b1;
    end else begin
      cnt_d = 9'(cnt_q + 9'h1);
      cyc_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      band_lead_q <= 3'h0;
      band_pwm_q  <= 3'h0;
      dir_q       <= 1'b0;
      brk_q       <= 1'b0;
      lead_q      <= 4'h0;
      div_q       <= 2'h0;
      cnt_q       <= 9'h000;
      cyc_q       <= 1'b0;
    end else begin
      band_lead_q <= band_lead_d;
      band_pwm_q  <= band_pwm_d;
      dir_q       <= dir_d;
      brk_q       <= brk_d;
      lead_q      <= lead_d;
      div_q       <= cyc_d ? div_d : div_q;
      cnt_q       <= cnt_d;
      cyc_q       <= cyc_d;
    end
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign dir_ccw_o     = dir_q;
  assign short_brake_o = brk_q;
  assign lead_angle_o  = lead_q;
  assign pwm_div_o     = div_q;
  assign pwm_cycle_o   = cyc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_dir_map: assert property (
    !sys_rst_i |=> dir_ccw_o == ($past(rotation_dir_pin_i) ^ $past(ctrl_q[DIRINV])))
    else $error("direction mapping wrong");
  chk_brake_map: assert property (
    !sys_rst_i |=> short_brake_o == ($past(ctrl_q[BRKINV]) ? !$past(brake_pin_i) : $past(brake_pin_i)))
    else $error("brake polarity wrong");
  chk_pwm_period: assert property (
    pwm_cycle_o && div_q == 2'h3 |=> !pwm_cycle_o [*8] ##56 pwm_cycle_o)
    else $error("divide by 64 period wrong");
  chk_fixed_div: assert property (
    pwm_cycle_o && ctrl_q[PWMF_LSB +: 3] < PWMF_BANDED && $stable(ctrl_q)
      |=> pwm_div_o == $past(ctrl_q[PWMF_LSB +: 2]))
    else $error("fixed divider not applied");
  chk_band_hyst: assert property (
    band_pwm_q == 3'h2 && elec_speed_hz_i > 16'd300 && elec_speed_hz_i <= 16'd600
      |=> band_pwm_q == 3'h2)
    else $error("pwm band left inside hysteresis");
  chk_lead_fixed: assert property (
    ctrl_q[LEAD_LSB +: 4] <= LEAD_FIXED_MAX && ctrl_q[COMM_LSB +: 2] == COMM_120
      |=> lead_angle_o == $past(ctrl_q[LEAD_LSB +: 4]))
    else $error("fixed lead angle wrong");
  chk_lead_scale: assert property (
    !sys_rst_i && ctrl_q[SCALE_LSB +: 2] == 2'h0 && band_lead_q == 3'h0 && elec_speed_hz_i > 16'd100
      |=> band_lead_q == 3'h1)
    else $error("fine lead band not entered");
  chk_lead_clamp: assert property (
    ctrl_q[COMM_LSB +: 2] == COMM_135 |=> lead_angle_o <= LEAD_LIM_135)
    else $error("lead angle not clamped");
  chk_apb_ready: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb ready not one cycle");
  chk_ctrl_write: assert property (
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == CTRL_OFS
      |=> ctrl_q == ($past(pwdata_i[15:0]) & CTRL_MASK))
    else $error("control write not taken at ready edge");

  cov_brake: cover property (short_brake_o ##1 !short_brake_o);
  cov_banded_pwm: cover property (pwm_cycle_o && pwm_div_o == 2'h3 && band_pwm_q == BAND_TOP);
  cov_var_lead: cover property (lead_angle_o == 4'h7 && ctrl_q[LEAD_LSB +: 4] == 4'hD);
  cov_err: cover property (pslverr_o);
endmodule // motor_drive_setting_select
`default_nettype wire

// ==== rtl/motor_set_pkg.sv ====
// Constants, register map and lookup tables for the drive setting selector
package motor_set_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  // Control register fields
  localparam int LEAD_LSB  = 0;   // lead_angle_sel [3:0]
  localparam int SCALE_LSB = 4;   // lead_band_scale [5:4]
  localparam int PWMF_LSB  = 8;   // pwm_freq_sel [10:8]
  localparam int DIRINV    = 12;  // direction invert
  localparam int BRKINV    = 13;  // brake_pol_invert
  localparam int COMM_LSB  = 14;  // commutation angle [15:14]
  localparam logic [15:0] CTRL_MASK  = 16'hF73F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Commutation angle codes
  localparam logic [1:0] COMM_120 = 2'h0;
  localparam logic [1:0] COMM_135 = 2'h1;
  // Lead angle in 3.75 degree units
  localparam logic [3:0] LEAD_FIXED_MAX = 4'h8;
  localparam logic [3:0] LEAD_LIM_120   = 4'h8;
  localparam logic [3:0] LEAD_LIM_135   = 4'h6;
  localparam logic [3:0] LEAD_LIM_150   = 4'h4;
  // Speed bands, electrical Hz
  localparam logic [2:0]  BAND_TOP    = 3'h5;
  localparam logic [15:0] STEP_FINE   = 16'h0064; // 100 Hz
  localparam logic [15:0] OFS_FINE    = 16'h0032; // 50 Hz
  localparam logic [15:0] STEP_COARSE = 16'h00C8; // 200 Hz
  localparam logic [15:0] OFS_COARSE  = 16'h0064; // 100 Hz
  // PWM divider: code 0..3 gives 512,256,128,64
  localparam logic [9:0] PWM_DIV_MAX = 10'h200;
  localparam logic [2:0] PWMF_BANDED = 3'h4;
  // Speed-dependent lead for codes 9..15, six bands each
  localparam logic [3:0] LEAD_TBL [0:6][0:5] = '{
    '{4'h2, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6},
    '{4'h2, 4'h2, 4'h4, 4'h4, 4'h5, 4'h6},
    '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5},
    '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6},
    '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7},
    '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8},
    '{4'h1, 4'h3, 4'h5, 4'h7, 4'h8, 4'h8}};
  // Banded divider code for pwm_freq_sel 4..7
  localparam logic [1:0] PWM_TBL [0:3][0:5] = '{
    '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3},
    '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2},
    '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2},
    '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3}};
endpackage
